// File: epci_consts.vh
`ifndef EPCI_CONSTS_VH
`define EPCI_CONSTS_VH
// register word indexes; the byte address is four times the index
`define EPCI_ADDR_FLAG 8'h3C
`define EPCI_ADDR_MASK0 8'h6B
`define EPCI_ADDR_MASK1 8'h6C
`define EPCI_ADDR_MASK3 8'h73
`define EPCI_ADDR_MASK2 8'h74
`define EPCI_ADDR_SENSE 8'h78
`define EPCI_ADDR_ENABLE 8'h7C
`define EPCI_ADDR_STATUS 8'h80
// index field of a byte address
`define EPCI_IDX_MSB 9
`define EPCI_IDX_LSB 2
// field positions in the enable and flag words
`define EPCI_BIT_EXT 0
`define EPCI_BIT_G0 4
`define EPCI_BIT_G1 5
`define EPCI_BIT_G2 6
`define EPCI_BIT_G3 7
// sense select encodings
`define EPCI_SENSE_LOW 2'h0
`define EPCI_SENSE_ANY 2'h1
`define EPCI_SENSE_FALL 2'h2
`define EPCI_SENSE_RISE 2'h3
// register reset values and write masks
`define EPCI_RESET_BYTE 8'h00
`define EPCI_FLAG_WMASK 8'hF1
`define EPCI_MASK3_WMASK 8'h7F
`define EPCI_SMALL_FLAG_MASK 8'h31
// axi responses
`define EPCI_RESP_OKAY 2'h0
`define EPCI_RESP_SLVERR 2'h2
`endif

// File: epci_pin_sync.v
`timescale 1ns/1ns
`default_nettype none
// two-flop synchroniser plus one history stage for edge detection
module epci_pin_sync #(
    parameter WIDTH = 32
) (
    input wire sys_clk,
    input wire rst_b,
    input wire [WIDTH-1:0] pin_in,
    output wire [WIDTH-1:0] pin_now,
    output wire [WIDTH-1:0] pin_prev
);
    reg [WIDTH-1:0] meta_reg;
    reg [WIDTH-1:0] sync_reg;
    reg [WIDTH-1:0] hist_reg;

    // first stage feeds only the second
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_reg <= {WIDTH{1'b1}};
            sync_reg <= {WIDTH{1'b1}};
            hist_reg <= {WIDTH{1'b1}};
        end else begin
            meta_reg <= pin_in;
            sync_reg <= meta_reg;
            hist_reg <= sync_reg;
        end
    end

    assign pin_now = sync_reg;
    assign pin_prev = hist_reg;
endmodule // epci_pin_sync
`default_nettype wire

// File: epci_irq_ctrl.v
`timescale 1ns/1ns
`default_nettype none
`include "epci_consts.vh"
module epci_irq_ctrl #(
    parameter LARGE_VARIANT = 1
) (
    input wire sys_clk,
    input wire rst_b,
    input wire [9:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [9:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire ext_irq_pin,
    input wire [30:0] pc_pins,
    input wire cpu_global_enable,
    input wire [4:0] irq_ack,
    output wire [4:0] irq_req,
    output wire ext_level_wake,
    output wire pc_wake
);
    reg [7:0] sense_reg;
    reg [7:0] enable_reg;
    reg [7:0] flag_reg;
    reg [7:0] flag_next;
    reg [7:0] mask0_reg;
    reg [7:0] mask1_reg;
    reg [7:0] mask2_reg;
    reg [7:0] mask3_reg;
    reg [7:0] aw_addr_reg;
    reg aw_full_reg;
    reg [31:0] w_data_reg;
    reg [3:0] w_strb_reg;
    reg w_full_reg;
    wire [31:0] pin_all;
    wire [31:0] pin_now;
    wire [31:0] pin_prev;
    wire [31:0] pin_mask;
    wire [31:0] pin_change;
    wire [3:0] grp_change;
    wire ext_now;
    wire ext_prev;
    reg ext_trig;
    wire [1:0] sense_sel;
    wire do_write;
    wire wr_byte0;
    wire [7:0] wr_val;
    wire [7:0] flag_read;
    wire [7:0] flag_avail;
    wire [7:0] wclr;
    wire [7:0] hclr;
    wire [7:0] set_vec;
    reg [7:0] rd_byte;
    reg rd_hit;
    reg wr_hit;
    wire [31:0] grp_en;
    wire [7:0] ar_idx;
    wire wr_flag;
    wire wr_mask0;
    wire wr_mask1;
    wire wr_mask2;
    wire wr_mask3;
    wire wr_sense;
    wire wr_enable;

    // trigger select sits in the low two bits of the sense word
    assign sense_sel = sense_reg[1:0];

    // external pin and all pin-change inputs share one sampler
    assign pin_all = {ext_irq_pin, pc_pins};
    epci_pin_sync #(
        .WIDTH(32)
    ) u_sync (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .pin_in(pin_all),
        .pin_now(pin_now),
        .pin_prev(pin_prev)
    );
    // pad input is read regardless of pin direction
    assign ext_now = pin_now[31];
    assign ext_prev = pin_prev[31];

    // per-pin mask vector; missing masks on small variant
    assign pin_mask = {1'b0, mask3_reg[6:0],
        (LARGE_VARIANT != 0) ? mask2_reg : 8'h00, mask1_reg, mask0_reg};
    // group enables spread over the eight pins of each group
    assign grp_en = {{8{enable_reg[`EPCI_BIT_G3]}},
        {8{enable_reg[`EPCI_BIT_G2]}},
        {8{enable_reg[`EPCI_BIT_G1]}},
        {8{enable_reg[`EPCI_BIT_G0]}}};
    // toggle counts only on a masked pin of an enabled group
    assign pin_change = (pin_now ^ pin_prev) & pin_mask & grp_en;
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_grp
            // any masked pin of the group toggles
            assign grp_change[g] = |pin_change[g*8+7:g*8];
        end
    endgenerate

    // sense decode for the clocked external trigger
    always @* begin
        case (sense_sel)
            `EPCI_SENSE_ANY: ext_trig = ext_now ^ ext_prev;
            `EPCI_SENSE_FALL: ext_trig = ext_prev & ~ext_now;
            `EPCI_SENSE_RISE: ext_trig = ~ext_prev & ext_now;
            default: ext_trig = 1'b0;
        endcase
    end

    // unclocked wake paths from raw pins
    assign ext_level_wake = (sense_sel == `EPCI_SENSE_LOW) &
        enable_reg[`EPCI_BIT_EXT] & ~ext_irq_pin;
    assign pc_wake = |((pin_all ^ pin_now) & pin_mask & grp_en);

    // bits that exist on this variant
    assign flag_avail = (LARGE_VARIANT != 0) ? `EPCI_FLAG_WMASK :
        `EPCI_SMALL_FLAG_MASK;

    // flag sets and clears
    assign set_vec = {grp_change[3], grp_change[2], grp_change[1],
        grp_change[0], 3'b000, ext_trig} & flag_avail;
    assign do_write = aw_full_reg & w_full_reg & ~s_axi_bvalid;
    assign wr_byte0 = do_write & w_strb_reg[0];
    assign wr_val = w_data_reg[7:0];
    // one write strobe per register, lane 0 carries the byte
    assign wr_flag = wr_byte0 && aw_addr_reg == `EPCI_ADDR_FLAG;
    assign wr_mask0 = wr_byte0 && aw_addr_reg == `EPCI_ADDR_MASK0;
    assign wr_mask1 = wr_byte0 && aw_addr_reg == `EPCI_ADDR_MASK1;
    assign wr_mask2 = wr_byte0 && aw_addr_reg == `EPCI_ADDR_MASK2 &&
        LARGE_VARIANT != 0;
    assign wr_mask3 = wr_byte0 && aw_addr_reg == `EPCI_ADDR_MASK3 &&
        LARGE_VARIANT != 0;
    assign wr_sense = wr_byte0 && aw_addr_reg == `EPCI_ADDR_SENSE;
    assign wr_enable = wr_byte0 && aw_addr_reg == `EPCI_ADDR_ENABLE;
    assign wclr = wr_flag ? wr_val : `EPCI_RESET_BYTE;
    assign hclr = {irq_ack[4:1], 3'b000, irq_ack[0]};
    // set beats clear; write-one and handler entry clear
    always @* begin
        flag_next = ((flag_reg & ~wclr & ~hclr) | set_vec) & flag_avail;
        // level mode keeps the external flag clear
        if (sense_sel == `EPCI_SENSE_LOW) begin
            flag_next[`EPCI_BIT_EXT] = 1'b0;
        end
    end
    // flag word as software sees it; level mode hides the external flag
    assign flag_read = flag_reg &
        ~{7'h00, sense_sel == `EPCI_SENSE_LOW};

    // requests: flag or live low level, gated by own and global enable
    assign irq_req[0] = cpu_global_enable & enable_reg[`EPCI_BIT_EXT] &
        ((sense_sel == `EPCI_SENSE_LOW) ? ~ext_now :
        flag_reg[`EPCI_BIT_EXT]);
    assign irq_req[4:1] = {4{cpu_global_enable}} & enable_reg[7:4] &
        flag_reg[7:4];

    // write channel capture, address and data in either order
    assign s_axi_awready = ~aw_full_reg;
    assign s_axi_wready = ~w_full_reg;
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg <= 32'h00000000;
            w_strb_reg <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `EPCI_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && !aw_full_reg) begin
                aw_full_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr[`EPCI_IDX_MSB:`EPCI_IDX_LSB];
            end
            if (s_axi_wvalid && !w_full_reg) begin
                w_full_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_full_reg <= 1'b0;
                w_full_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? `EPCI_RESP_OKAY : `EPCI_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // write index decode; each register owns one aligned word
    always @* begin
        case (aw_addr_reg)
            `EPCI_ADDR_FLAG, `EPCI_ADDR_MASK0, `EPCI_ADDR_MASK1,
            `EPCI_ADDR_MASK3, `EPCI_ADDR_MASK2, `EPCI_ADDR_SENSE,
            `EPCI_ADDR_ENABLE: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    // flag word; a set beats a same-cycle clear
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            flag_reg <= `EPCI_RESET_BYTE;
        end else begin
            flag_reg <= flag_next;
        end
    end

    // control registers; reserved enables kept zero on small variant
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            sense_reg <= `EPCI_RESET_BYTE;
            enable_reg <= `EPCI_RESET_BYTE;
            mask0_reg <= `EPCI_RESET_BYTE;
            mask1_reg <= `EPCI_RESET_BYTE;
            mask2_reg <= `EPCI_RESET_BYTE;
            mask3_reg <= `EPCI_RESET_BYTE;
        end else begin
            if (wr_sense) begin
                sense_reg <= {6'h00, wr_val[1:0]};
            end
            if (wr_enable) begin
                enable_reg <= wr_val & flag_avail;
            end
            if (wr_mask0) begin
                mask0_reg <= wr_val;
            end
            if (wr_mask1) begin
                mask1_reg <= wr_val;
            end
            if (wr_mask2) begin
                mask2_reg <= wr_val;
            end
            if (wr_mask3) begin
                mask3_reg <= wr_val & `EPCI_MASK3_WMASK;
            end
        end
    end

    // read decode by word index, byte returned in lane 0
    assign ar_idx = s_axi_araddr[`EPCI_IDX_MSB:`EPCI_IDX_LSB];
    always @* begin
        rd_hit = 1'b1;
        rd_byte = 8'h00;
        case (ar_idx)
            `EPCI_ADDR_FLAG: rd_byte = flag_read;
            `EPCI_ADDR_MASK0: rd_byte = mask0_reg;
            `EPCI_ADDR_MASK1: rd_byte = mask1_reg;
            `EPCI_ADDR_MASK3: rd_byte = mask3_reg;
            `EPCI_ADDR_MASK2: rd_byte = mask2_reg;
            `EPCI_ADDR_SENSE: rd_byte = sense_reg;
            `EPCI_ADDR_ENABLE: rd_byte = enable_reg;
            `EPCI_ADDR_STATUS: rd_byte = {7'h00, ext_now};
            default: rd_hit = 1'b0;
        endcase
    end

    // read channel: one-cycle answer, held until rready
    assign s_axi_arready = ~s_axi_rvalid;
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `EPCI_RESP_OKAY;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= rd_hit ? `EPCI_RESP_OKAY : `EPCI_RESP_SLVERR;
            s_axi_rdata <= {24'h000000, rd_byte};
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule // epci_irq_ctrl
`default_nettype wire

// File: epci_checker.sv
`timescale 1ns/1ns
`default_nettype none
// port-level timing and gating checks
module epci_checker (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic ext_irq_pin,
    input wire logic cpu_global_enable,
    input wire logic [4:0] irq_req,
    input wire logic ext_level_wake
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    // requests need the global enable
    a_req_global: assert property (irq_req != 5'h00 |->
        cpu_global_enable) else $error("request while globally off");
    // raw wake only while the pin is low
    a_level_wake: assert property (ext_level_wake |->
        !ext_irq_pin) else $error("level wake with pin high");
    // a held low level gives a request
    a_level_req: assert property (ext_level_wake [*4] ##0
        cpu_global_enable |-> irq_req[0]) else $error("no level request");
    // answers stand until taken
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("b dropped");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("r dropped");
    // answer latency
    a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid) else $error("read answer late");
    a_b_answer: assert property (s_axi_awvalid && s_axi_awready &&
        s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid)
        else $error("write answer late");
    a_ar_block: assert property (s_axi_rvalid && s_axi_rready |=>
        !s_axi_rvalid) else $error("second read taken");
    // main scenarios
    c_ext: cover property (irq_req[0]);
    c_grp3: cover property (irq_req[4]);
    c_err: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule // epci_checker
bind epci_irq_ctrl epci_checker u_chk (.sys_clk, .rst_b, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .ext_irq_pin,
    .cpu_global_enable, .irq_req, .ext_level_wake);
`default_nettype wire

// File: epci_pin_model.sv
`timescale 1ns/1ns
`default_nettype none
// far-side pins, levels follow the bench one edge later
module epci_pin_model (
    input wire logic sys_clk,
    input wire logic ext_want,
    input wire logic [30:0] pc_want,
    output logic ext_irq_pin,
    output logic [30:0] pc_pins
);
    // each level is held until a new one is asked for
    always @(posedge sys_clk) begin
        ext_irq_pin <= ext_want;
        pc_pins <= pc_want;
    end
endmodule // epci_pin_model
`default_nettype wire

// File: epci_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "epci_consts.vh"
module tb;
    logic sys_clk = 1'h0;
    logic rst_b = 1'h0;
    logic [9:0] s_axi_awaddr = 10'h000;
    logic [9:0] s_axi_araddr = 10'h000;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awvalid = 1'h0;
    logic s_axi_wvalid = 1'h0;
    logic s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0;
    logic s_axi_rready = 1'h0;
    logic cpu_global_enable = 1'h0;
    logic ext_want = 1'h1;
    // pins idle high, the level the sampler resets to
    logic [30:0] pc_want = 31'h7FFFFFFF;
    logic [4:0] irq_ack = 5'h00;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, ext_irq_pin, ext_level_wake, pc_wake;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata, rd, m;
    logic [4:0] irq_req;
    logic [30:0] pc_pins;
    logic [7:0] ra [7] = '{`EPCI_ADDR_FLAG, `EPCI_ADDR_MASK0,
        `EPCI_ADDR_MASK1, `EPCI_ADDR_MASK2, `EPCI_ADDR_MASK3,
        `EPCI_ADDR_SENSE, `EPCI_ADDR_ENABLE};
    int num_errors = 0;
    int n_tests = 0;
    epci_irq_ctrl #(.LARGE_VARIANT(1)) dut (.sys_clk, .rst_b,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .ext_irq_pin, .pc_pins, .cpu_global_enable,
        .irq_ack, .irq_req, .ext_level_wake, .pc_wake);
    epci_pin_model u_pins (.sys_clk, .ext_want, .pc_want, .ext_irq_pin,
        .pc_pins);
    // 125 MHz clock
    always #4 sys_clk = ~sys_clk;
    // word index of each group's mask
    function automatic [7:0] ma(input int g);
        ma = (g == 0) ? `EPCI_ADDR_MASK0 : (g == 1) ? `EPCI_ADDR_MASK1 :
            (g == 2) ? `EPCI_ADDR_MASK2 : `EPCI_ADDR_MASK3;
    endfunction
    function automatic [31:0] mw(input int g);
        mw = (g == 3) ? 32'h7F : 32'hFF;
    endfunction
    task automatic chk(input [31:0] got, input [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wrap_up;
        $display("compares %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // axi write, address and data offered together
    task automatic wr(input [7:0] a, input [31:0] d, input [3:0] s,
        input [1:0] er);
        logic ad;
        logic wd;
        ad = 1'h0;
        wd = 1'h0;
        s_axi_awaddr <= {a, 2'h0};
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        while (!(ad && wd)) begin
            @(posedge sys_clk);
            ad = ad | s_axi_awready;
            wd = wd | s_axi_wready;
            s_axi_awvalid <= !ad;
            s_axi_wvalid <= !wd;
        end
        do @(posedge sys_clk); while (s_axi_bvalid !== 1'h1);
        s_axi_bready <= 1'h0;
        chk(32'(s_axi_bresp), 32'(er));
        @(posedge sys_clk);
    endtask
    // axi read into rd
    task automatic rr(input [7:0] a, input [1:0] er);
        s_axi_araddr <= {a, 2'h0};
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do @(posedge sys_clk); while (s_axi_arready !== 1'h1);
        s_axi_arvalid <= 1'h0;
        do @(posedge sys_clk); while (s_axi_rvalid !== 1'h1);
        rd = s_axi_rdata;
        s_axi_rready <= 1'h0;
        chk(32'(s_axi_rresp), 32'(er));
        @(posedge sys_clk);
    endtask
    // main sequence
    initial begin
        m = $urandom(6);
        repeat (4) @(posedge sys_clk);
        rst_b <= 1'h1;
        @(posedge sys_clk);
        for (int i = 0; i < 7; i++) begin
            rr(ra[i], 2'h0);
            chk(rd, 32'h0);
        end
        rr(8'h00, 2'h2);
        wr(8'h00, 32'hFF, 4'hF, 2'h2);
        $display("test reset and map done");
        cpu_global_enable <= 1'h1;
        wr(8'h7C, 32'hF1, 4'h1, 2'h0);
        for (int g = 0; g < 4; g++) begin
            m = ($urandom & 32'hFD) | 32'h81;
            wr(ma(g), m, 4'h1, 2'h0);
            rr(ma(g), 2'h0);
            chk(rd, m & mw(g));
            pc_want[8 * g + 1] <= ~pc_want[8 * g + 1];
            repeat (2) @(posedge sys_clk);
            chk(32'(pc_wake), 32'h0);
            repeat (4) @(posedge sys_clk);
            rr(8'h3C, 2'h0);
            chk(rd, 32'h0);
            pc_want[8 * g] <= ~pc_want[8 * g];
            repeat (2) @(posedge sys_clk);
            chk(32'(pc_wake), 32'h1);
            repeat (4) @(posedge sys_clk);
            rr(8'h3C, 2'h0);
            chk(rd, 32'h10 << g);
            chk(32'(irq_req), 32'h2 << g);
            irq_ack[g + 1] <= 1'h1;
            @(posedge sys_clk);
            irq_ack <= 5'h00;
            rr(8'h3C, 2'h0);
            chk(rd, 32'h0);
        end
        $display("test pin groups done");
        cpu_global_enable <= 1'h0;
        pc_want[0] <= ~pc_want[0];
        repeat (6) @(posedge sys_clk);
        chk(32'(irq_req), 32'h0);
        rr(8'h3C, 2'h0);
        chk(rd, 32'h10);
        wr(8'h3C, 32'h10, 4'h1, 2'h0);
        rr(8'h3C, 2'h0);
        chk(rd, 32'h0);
        // groups switched off: masked toggle must not count
        wr(8'h7C, 32'h01, 4'h1, 2'h0);
        pc_want[0] <= ~pc_want[0];
        repeat (2) @(posedge sys_clk);
        chk(32'(pc_wake), 32'h0);
        repeat (4) @(posedge sys_clk);
        rr(8'h3C, 2'h0);
        chk(rd, 32'h0);
        cpu_global_enable <= 1'h1;
        for (int s = 1; s < 4; s++) begin
            wr(8'h78, 32'(s), 4'h1, 2'h0);
            ext_want <= 1'h0;
            repeat (6) @(posedge sys_clk);
            rr(8'h3C, 2'h0);
            chk(rd, 32'(s != 3));
            wr(8'h3C, 32'h01, 4'h1, 2'h0);
            ext_want <= 1'h1;
            repeat (6) @(posedge sys_clk);
            rr(8'h3C, 2'h0);
            chk(rd, 32'(s != 2));
            wr(8'h3C, 32'h01, 4'h1, 2'h0);
        end
        $display("test edge modes done");
        wr(8'h78, 32'h0, 4'h1, 2'h0);
        ext_want <= 1'h0;
        repeat (6) @(posedge sys_clk);
        chk(32'(irq_req), 32'h1);
        chk(32'(ext_level_wake), 32'h1);
        rr(8'h3C, 2'h0);
        chk(rd, 32'h0);
        ext_want <= 1'h1;
        repeat (6) @(posedge sys_clk);
        chk(32'(irq_req), 32'h0);
        $display("test level mode done");
        wrap_up;
    end
    // watchdog, far beyond the expected run
    initial begin
        #100000;
        num_errors++;
        wrap_up;
    end
endmodule // tb
`default_nettype wire
